// >>> core/addr_mode_pkg.sv
/*
 Shared constants and types for the addressing-mode and operand address generator.
 Assumes an 8-bit core with a 16-bit memory address bus on one clock.
*/
package addr_mode_pkg;

   // Addressing modes handled by this block.
   typedef enum logic [1:0] {
      no_operand_mode       = 2'b00,
      constant_operand_mode = 2'b01,
      short_absolute_mode   = 2'b10,
      long_absolute_mode    = 2'b11
   } addr_mode_t;

   // Sequencer states.
   typedef enum logic [2:0] {
      st_idle   = 3'b000,
      st_fetch1 = 3'b001,
      st_fetch2 = 3'b010,
      st_access = 3'b011,
      st_done   = 3'b100
   } seq_state_t;

   localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
   localparam logic [15:0] PC_STEP_TWO   = 16'h0002;
   localparam logic [15:0] PC_STEP_THREE = 16'h0003;
   localparam logic [7:0]  PAGE_ZERO     = 8'h00;
   localparam logic [15:0] ADDR_RESET    = 16'h0000;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam int          HALF_CARRY_BIT = 3;

   // Flag positions inside the condition flags register.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_I = 3;
   localparam int FLAG_H = 4;
   localparam logic [4:0] FLAGS_RESET = 5'h08;

endpackage

// >>> core/cpu_address_mode_decode.sv
/*
 Addressing-mode sequencer: instruction length, program counter advance, operand address.
 Assumes a memory that returns read data on mem_rdata in the same cycle as mem_addr/mem_rd,
 so that the byte is settled at the rising edge that closes the read cycle.
*/
//
// Overview of operation
// [RQ1] No-operand mode: one byte, no operand fetch.
// [RQ2] Constant mode: operand at PC+1, PC advances two.
// [RQ3] Short absolute: high byte zero, low from operand.
// [RQ4] Long absolute: high then low byte, PC+3.
// [RQ5] Half carry comes from bit 3 carry.
// [RQ6] Interrupt return reloads all flags from stack.
// [RQ7] Operand address driven on full 16-bit bus.
`timescale 1ns/1ps
module cpu_address_mode_decode
   import addr_mode_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        start,
   input  wire addr_mode_t  mode,
   input  wire logic [15:0] opcode_pc,
   input  wire logic        op_write,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        arith_valid,
   input  wire logic        half_carry_en,
   input  wire logic [7:0]  arith_a,
   input  wire logic [7:0]  arith_b,
   input  wire logic        arith_cin,
   input  wire logic        interrupt_return,
   input  wire logic [4:0]  stacked_flags,
   output logic             busy,
   output logic [15:0]      mem_addr,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic [15:0]      operand_address,
   output logic [15:0]      next_pc,
   output logic [1:0]       instr_length,
   output logic             done,
   output logic [4:0]       condition_flags_register
);

   seq_state_t  state_reg,   state_next;
   addr_mode_t  mode_reg,    mode_next;
   logic [15:0] pc_reg,      pc_next;
   logic [15:0] addr_reg,    addr_next;
   logic [15:0] npc_reg,     npc_next;
   logic [1:0]  len_reg,     len_next;
   logic        wr_reg,      wr_next;
   logic        rd_reg,      rd_next;
   logic        hi_pend_reg, hi_pend_next;
   logic [7:0]  hi_reg,      hi_next;

   // Program counter step for a mode, used for length and advance.
   function automatic logic [15:0] pc_step(input addr_mode_t m);
      case (m)
         no_operand_mode:       pc_step = PC_STEP_ONE;
         constant_operand_mode: pc_step = PC_STEP_TWO;
         short_absolute_mode:   pc_step = PC_STEP_TWO;
         long_absolute_mode:    pc_step = PC_STEP_THREE;
         default:               pc_step = PC_STEP_ONE;
      endcase
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // Sequencer next-state logic.
   always_comb begin
      state_next   = state_reg;
      mode_next    = mode_reg;
      pc_next      = pc_reg;
      addr_next    = addr_reg;
      npc_next     = npc_reg;
      len_next     = len_reg;
      wr_next      = wr_reg;
      rd_next      = 1'b0;
      hi_pend_next = hi_pend_reg;
      hi_next      = hi_reg;
      case (state_reg)
         st_idle: begin
            if (start) begin
               mode_next = mode;
               pc_next   = opcode_pc;
               wr_next   = op_write;
               npc_next  = opcode_pc + pc_step(mode); // RQ2 RQ4
               len_next  = pc_step(mode) == PC_STEP_THREE ? 2'd3 :
                           pc_step(mode) == PC_STEP_TWO   ? 2'd2 : 2'd1;
               case (mode)
                  no_operand_mode: begin
                     state_next = st_done; // RQ1
                  end
                  constant_operand_mode: begin
                     addr_next  = opcode_pc + PC_STEP_ONE; // RQ2
                     state_next = st_access;
                  end
                  default: begin
                     addr_next  = opcode_pc + PC_STEP_ONE;
                     rd_next    = 1'b1;
                     state_next = st_fetch1;
                  end
               endcase
            end
         end
         st_fetch1: begin
            if (mode_reg == long_absolute_mode) begin
               hi_next    = mem_rdata; // RQ4
               addr_next  = pc_reg + PC_STEP_TWO;
               rd_next    = 1'b1;
               state_next = st_fetch2;
            end else begin
               addr_next  = {PAGE_ZERO, mem_rdata}; // RQ3
               state_next = st_access;
            end
         end
         st_fetch2: begin
            addr_next  = {hi_reg, mem_rdata}; // RQ4
            state_next = st_access;
         end
         st_access: begin
            state_next = st_done;
         end
         st_done: begin
            state_next = st_idle;
         end
         default: begin
            state_next = st_idle;
         end
      endcase
      hi_pend_next = (state_next == st_fetch2);
   end

   // Sequencer registers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg   <= st_idle;
         mode_reg    <= no_operand_mode;
         pc_reg      <= ADDR_RESET;
         addr_reg    <= ADDR_RESET;
         npc_reg     <= ADDR_RESET;
         len_reg     <= 2'd1;
         wr_reg      <= 1'b0;
         rd_reg      <= 1'b0;
         hi_pend_reg <= 1'b0;
         hi_reg      <= BYTE_RESET;
      end else if (clk_en) begin
         state_reg   <= state_next;
         mode_reg    <= mode_next;
         pc_reg      <= pc_next;
         addr_reg    <= addr_next;
         npc_reg     <= npc_next;
         len_reg     <= len_next;
         wr_reg      <= wr_next;
         rd_reg      <= rd_next;
         hi_pend_reg <= hi_pend_next;
         hi_reg      <= hi_next;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Bus drive: operand byte fetches, then the operand access itself.
   assign mem_addr        = addr_reg; // RQ7
   // A constant operand is always read, whatever the store request says.
   assign mem_rd          = rd_reg || (state_reg == st_access
                            && (!wr_reg || mode_reg == constant_operand_mode)); // RQ2
   assign mem_wr          = (state_reg == st_access) && wr_reg
                            && mode_reg != constant_operand_mode;
   assign operand_address = addr_reg;
   assign next_pc         = npc_reg;
   assign instr_length    = len_reg;
   assign busy            = state_reg != st_idle;
   assign done            = state_reg == st_done;

   // Flag register with half carry and interrupt-return reload.
   flag_update u_flags (
      .clk                      (clk),
      .reset                    (reset),
      .clk_en                   (clk_en),
      .arith_valid              (arith_valid),
      .half_carry_en            (half_carry_en),
      .arith_a                  (arith_a),
      .arith_b                  (arith_b),
      .arith_cin                (arith_cin),
      .interrupt_return         (interrupt_return),
      .stacked_flags            (stacked_flags),
      .condition_flags_register (condition_flags_register)
   );

   a_noop_len: assert property (@(posedge clk) disable iff (reset) // RQ1
      (clk_en && state_reg == st_idle && start && mode == no_operand_mode) |=>
      (state_reg == st_done && instr_length == 2'd1 && !mem_rd))
      else $error("No-operand instruction not one byte.");

   a_const_addr: assert property (@(posedge clk) disable iff (reset) // RQ2
      (clk_en && state_reg == st_idle && start && mode == constant_operand_mode) |=>
      (mem_addr == $past(opcode_pc) + PC_STEP_ONE && mem_rd
       && next_pc == $past(opcode_pc) + PC_STEP_TWO))
      else $error("Constant operand address or advance wrong.");

   a_short_page: assert property (@(posedge clk) disable iff (reset) // RQ3
      (state_reg == st_access && mode_reg == short_absolute_mode)
      |-> (mem_addr[15:8] == PAGE_ZERO))
      else $error("Short absolute high byte not zero.");

   a_long_advance: assert property (@(posedge clk) disable iff (reset) // RQ4
      (clk_en && state_reg == st_fetch2) |=>
      (mem_addr == {$past(hi_reg), $past(mem_rdata)} && instr_length == 2'd3))
      else $error("Long absolute address wrong.");

   // The second operand byte is read from the location after the high byte.
   a_long_pair: assert property (@(posedge clk) disable iff (reset) // RQ4
      hi_pend_reg |-> (mem_rd && mem_addr == pc_reg + PC_STEP_TWO))
      else $error("Low address byte not fetched after high byte.");

   // Nothing in the sequencer moves while the clock enable is low.
   a_freeze_hold: assert property (@(posedge clk) disable iff (reset) // RQ7
      !clk_en |=> ($stable(state_reg) && $stable(addr_reg) && $stable(npc_reg)))
      else $error("Sequencer state moved with clock enable low.");

   a_bus_access: assert property (@(posedge clk) disable iff (reset) // RQ7
      (state_reg == st_access) |-> (mem_addr == operand_address && (mem_rd || mem_wr)))
      else $error("Operand address not on bus during access.");

   c_noop: cover property (@(posedge clk) state_reg == st_done && mode_reg == no_operand_mode);
   c_short: cover property (@(posedge clk) state_reg == st_access
                            && mode_reg == short_absolute_mode);
   c_long_wr: cover property (@(posedge clk) mem_wr && mode_reg == long_absolute_mode);
   c_const_rd: cover property (@(posedge clk) mem_rd && state_reg == st_access
                               && mode_reg == constant_operand_mode);

endmodule

// >>> core/flag_update.sv
/*
 Condition flags register with half-carry generation and reload on interrupt return.
 Assumes the surrounding core supplies adder operands, update strobes and the stacked flags.
*/
`timescale 1ns/1ps
module flag_update
   import addr_mode_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic       arith_valid,
   input  wire logic       half_carry_en,
   input  wire logic [7:0] arith_a,
   input  wire logic [7:0] arith_b,
   input  wire logic       arith_cin,
   input  wire logic       interrupt_return,
   input  wire logic [4:0] stacked_flags,
   output logic      [4:0] condition_flags_register
);

   logic [4:0] flags_reg;
   logic [4:0] flags_next;
   logic [4:0] low_sum;

   ///////////////////////////////////////////////////////////////////////////
   // Next flag value: a return reloads everything, else half carry updates.
   always_comb begin
      low_sum    = {1'b0, arith_a[3:0]} + {1'b0, arith_b[3:0]} + {4'h0, arith_cin};
      flags_next = flags_reg;
      if (interrupt_return) begin
         flags_next = stacked_flags; // RQ6
      end else if (arith_valid && half_carry_en) begin
         flags_next[FLAG_H] = low_sum[HALF_CARRY_BIT + 1]; // RQ5
      end
   end

   // Flag register, frozen while the clock enable is low.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags_reg <= FLAGS_RESET;
      end else if (clk_en) begin
         flags_reg <= flags_next;
      end
   end

   assign condition_flags_register = flags_reg;

   a_rti_reload: assert property (@(posedge clk) disable iff (reset) // RQ6
      (clk_en && interrupt_return) |=> (flags_reg == $past(stacked_flags)))
      else $error("Flags not reloaded on interrupt return.");

   a_half_carry: assert property (@(posedge clk) disable iff (reset) // RQ5
      (clk_en && !interrupt_return && arith_valid && half_carry_en) |=>
      (flags_reg[FLAG_H] == $past(low_sum[HALF_CARRY_BIT + 1])))
      else $error("Half carry does not match carry out of bit 3.");

   a_flag_freeze: assert property (@(posedge clk) disable iff (reset) // RQ6
      !clk_en |=> $stable(flags_reg))
      else $error("Flags changed with clock enable low.");

endmodule

// >>> verif/cpu_address_mode_decode_tb_top.sv
/*
 Self-checking bench for the addressing-mode sequencer and its flags.
 Assumes the operand memory model and the shared package are compiled first.
*/
`timescale 1ns/1ps
module cpu_address_mode_decode_tb_top
   import addr_mode_pkg::*;
;
   logic        clk, reset, clk_en, start, op_write, arith_valid, half_carry_en;
   logic        arith_cin, interrupt_return, busy, mem_rd, mem_wr, done;
   addr_mode_t  mode;
   logic [15:0] opcode_pc, mem_addr, operand_address, next_pc;
   logic [7:0]  mem_rdata, arith_a, arith_b;
   logic [4:0]  stacked_flags, condition_flags_register, flags_exp;
   logic [1:0]  instr_length;
   int          n_fail, checks_done, cycles;

   cpu_address_mode_decode dut (.clk(clk), .reset(reset), .clk_en(clk_en), .start(start),
      .mode(mode), .opcode_pc(opcode_pc), .op_write(op_write), .mem_rdata(mem_rdata),
      .arith_valid(arith_valid), .half_carry_en(half_carry_en), .arith_a(arith_a),
      .arith_b(arith_b), .arith_cin(arith_cin), .interrupt_return(interrupt_return),
      .stacked_flags(stacked_flags), .busy(busy), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .operand_address(operand_address), .next_pc(next_pc),
      .instr_length(instr_length), .done(done),
      .condition_flags_register(condition_flags_register));
   operand_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata));

   ////////////////////////////////////////////////////////////////////////
   // Expected memory byte, worked out independently of the model.
   function automatic logic [7:0] mbyte(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction

   // Compares one value and counts the result.
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Runs one instruction and checks bus accesses, length and next address.
   task automatic run_instr(input addr_mode_t m, input logic [15:0] pc, input logic wr);
      logic [15:0] q[$];
      logic [15:0] e[$];
      int          k;
      logic        wseen;
      e = {};
      if (m != no_operand_mode) e.push_back(pc + 16'h0001);
      if (m == short_absolute_mode) e.push_back({8'h00, mbyte(pc + 16'h0001)});
      if (m == long_absolute_mode) begin
         e.push_back(pc + 16'h0002);
         e.push_back({mbyte(pc + 16'h0001), mbyte(pc + 16'h0002)});
      end
      @(negedge clk);
      start = 1'b1; mode = m; opcode_pc = pc; op_write = wr;
      @(negedge clk);
      start = 1'b0; k = 1; wseen = 1'b0;
      while (done !== 1'b1 && k < 12) begin
         if (mem_rd === 1'b1 || mem_wr === 1'b1) q.push_back(mem_addr);
         if (mem_wr === 1'b1) wseen = 1'b1;
         @(negedge clk);
         k++;
      end
      chk("done", 16'h0001, {15'h0000, done});
      chk("latency", m + 1, k);
      chk("accesses", e.size(), q.size());
      for (int i = 0; i < e.size() && i < q.size(); i++) chk("addr", e[i], q[i]);
      chk("store", {15'h0000, wr && m >= short_absolute_mode}, {15'h0000, wseen});
      chk("length", (m == long_absolute_mode) ? 3 : (m == no_operand_mode) ? 1 : 2,
          {14'h0000, instr_length});
      chk("next_pc", pc + ((m == long_absolute_mode) ? 3 : (m == no_operand_mode) ? 1 : 2),
          next_pc);
      if (m != no_operand_mode) chk("operand", e[e.size() - 1], operand_address);
   endtask

   // Freezes a long-absolute instruction with a flag reload requested, then lets the instruction finish with the reload withdrawn.
   task automatic stall_instr(input logic [15:0] pc);
      logic [15:0] held;
      @(negedge clk);
      start = 1'b1; mode = long_absolute_mode; opcode_pc = pc; op_write = 1'b0;
      @(negedge clk);
      start = 1'b0;
      held = mem_addr;
      clk_en = 1'b0; interrupt_return = 1'b1; stacked_flags = ~flags_exp;
      repeat (3) @(negedge clk);
      chk("frozen addr", held, mem_addr);
      chk("frozen busy", 16'h0001, {15'h0000, busy});
      chk("frozen flags", {11'h000, flags_exp}, {11'h000, condition_flags_register});
      clk_en = 1'b1; interrupt_return = 1'b0;
      repeat (3) @(negedge clk);
      chk("stall done", 16'h0001, {15'h0000, done});
      chk("stall operand", {mbyte(pc + 16'h0001), mbyte(pc + 16'h0002)}, operand_address);
   endtask

   // Drives one flag-update cycle and checks the flags that follow.
   task automatic flag_op(input logic [7:0] a, input logic [7:0] b, input logic cin,
                          input logic en, input logic ret, input logic [4:0] sf);
      if (en) flags_exp[FLAG_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + cin) > 5'h0F;
      if (ret) flags_exp = sf;
      @(negedge clk);
      arith_a = a; arith_b = b; arith_cin = cin; arith_valid = 1'b1;
      half_carry_en = en; interrupt_return = ret; stacked_flags = sf;
      @(negedge clk);
      arith_valid = 1'b0; interrupt_return = 1'b0;
      chk("flags", {11'h000, flags_exp}, {11'h000, condition_flags_register});
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         finish_test();
      end
   end

   // Main sequence.
   initial begin
      n_fail = 0; checks_done = 0; cycles = 0;
      reset = 1'b1; clk_en = 1'b1; start = 1'b0; mode = no_operand_mode;
      opcode_pc = 16'h0000; op_write = 1'b0; arith_valid = 1'b0; half_carry_en = 1'b0;
      arith_a = 8'h00; arith_b = 8'h00; arith_cin = 1'b0; interrupt_return = 1'b0;
      stacked_flags = 5'h00; flags_exp = FLAGS_RESET;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      chk("reset flags", {11'h000, FLAGS_RESET}, {11'h000, condition_flags_register});
      run_instr(no_operand_mode, 16'h1000, 1'b0);
      run_instr(constant_operand_mode, 16'h20FE, 1'b1);
      run_instr(short_absolute_mode, 16'h00FF, 1'b0);
      run_instr(short_absolute_mode, 16'h4321, 1'b1);
      run_instr(long_absolute_mode, 16'hFFFE, 1'b0);
      run_instr(long_absolute_mode, 16'h8000, 1'b1);
      stall_instr(16'h1234);
      flag_op(8'h0F, 8'h01, 1'b0, 1'b1, 1'b0, 5'h00);
      flag_op(8'h07, 8'h08, 1'b0, 1'b1, 1'b0, 5'h00);
      flag_op(8'hF8, 8'h07, 1'b1, 1'b1, 1'b0, 5'h00);
      flag_op(8'h0F, 8'h0F, 1'b0, 1'b0, 1'b0, 5'h00);
      flag_op(8'h0F, 8'h0F, 1'b1, 1'b1, 1'b1, 5'h15);
      flag_op(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 5'h0A);
      finish_test();
   end
endmodule

// >>> verif/operand_mem_model.sv
/*
 Behavioural memory on the operand bus of the address-mode sequencer.
 Assumes one clock and read data answered in the same cycle as the read strobe.
*/
`timescale 1ns/1ps
module operand_mem_model (
   input  wire logic        clk,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   output logic      [7:0]  mem_rdata
);
   ////////////////////////////////////////////////////////////////////////
   // Answers a read at once with a byte derived from the address.
   // Between reads a byte that toggles every clock stands there, so stale data never looks valid.
   logic [7:0] idle_byte;
   initial idle_byte = 8'hA5;
   always @(posedge clk) begin
      idle_byte <= ~idle_byte;
   end
   always_comb begin
      mem_rdata = mem_rd ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3C) : idle_byte;
   end
endmodule
